// ---- test/lfsrc_host.sv ----
// Register bus and strobe master that stands in for the CPU side.
`timescale 1ns/1ns
`include "lfsrc_map.svh"
module lfsrc_host (
  input  wire logic                   clk_i,
  input  wire lfsrc_pkg::lfsrc_byte_t rdata_i,
  output logic                        wr_o,
  output logic                        rd_o,
  output logic                        csp_o,
  output lfsrc_pkg::lfsrc_byte_t      addr_o,
  output lfsrc_pkg::lfsrc_byte_t      wdata_o
);
  import lfsrc_pkg::*;
  initial begin
    {wr_o, rd_o, csp_o} = 3'h0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // Idle lines flip every cycle, so stale data never passes for fresh.
  task automatic put(input logic w, r, c, input lfsrc_byte_t a, d);
    @(negedge clk_i);
    {wr_o, rd_o, csp_o} = {w, r, c};
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
  endtask
  task automatic idle(input int n);
    repeat (n) put(1'b0, 1'b0, 1'b0, ~addr_o, ~wdata_o);
  endtask
  task automatic strobe(input int n);
    repeat (n) put(1'b0, 1'b0, 1'b1, ~addr_o, ~wdata_o);
  endtask
  // Writes may follow each other on consecutive edges.
  task automatic write(input lfsrc_byte_t a, d);
    put(1'b1, 1'b0, 1'b0, a, d);
  endtask
  task automatic read(input lfsrc_byte_t a, output lfsrc_byte_t d);
    put(1'b0, 1'b1, 1'b0, a, ~wdata_o);
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
  // The first byte written ends up in the high half.
  task automatic seed(input lfsrc_word_t s);
    write(`LFSRC_ADDR_LOW, s[15:8]);
    write(`LFSRC_ADDR_LOW, s[7:0]);
  endtask
endmodule

// ---- test/lfsrc_top_test.sv ----
// Self-checking bench for the random and CRC unit.
`timescale 1ns/1ns
`include "lfsrc_map.svh"
module lfsrc_top_test;
  import lfsrc_pkg::*;
  logic             clk, rst_n;
  wire logic        wr, rd, csp, ready;
  wire lfsrc_byte_t addr, wdata, rdata, rbyte;
  lfsrc_word_t      exp_w;
  int               fail_count;
  int               n_compared;

  lfsrc_top lfsrc_top_inst (
    .core_clk_i     (clk),
    .rst_n_i        (rst_n),
    .sfr_wr_i       (wr),
    .sfr_rd_i       (rd),
    .sfr_addr_i     (addr),
    .sfr_wdata_i    (wdata),
    .sfr_rdata_o    (rdata),
    .csp_rand_rd_i  (csp),
    .csp_rand_byte_o(rbyte),
    .crc_in_ready_o (ready)
  );
  lfsrc_host lfsrc_host_inst (
    .clk_i  (clk),
    .rdata_i(rdata),
    .wr_o   (wr),
    .rd_o   (rd),
    .csp_o  (csp),
    .addr_o (addr),
    .wdata_o(wdata)
  );

  // One Galois shift of the reference register.
  function automatic lfsrc_word_t step(lfsrc_word_t s, logic b);
    return {s[14:0], 1'b0} ^ ((s[15] ^ b) ? 16'h8005 : 16'h0000);
  endfunction
  function automatic lfsrc_word_t adv(lfsrc_word_t s);
    for (int i = 0; i < 13; i++) s = step(s, 1'b0);
    return s;
  endfunction
  function automatic lfsrc_word_t crc(lfsrc_word_t s, lfsrc_byte_t b);
    for (int i = 7; i >= 0; i--) s = step(s, b[i]);
    return s;
  endfunction

  task automatic chk(input lfsrc_byte_t got, exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic chk_word(input lfsrc_word_t w);
    lfsrc_byte_t d;
    lfsrc_host_inst.read(`LFSRC_ADDR_LOW, d);
    chk(d, w[7:0]);
    lfsrc_host_inst.read(`LFSRC_ADDR_HIGH, d);
    chk(d, w[15:8]);
    chk(rbyte, w[7:0]);
    chk({7'h00, ready}, 8'h01);
  endtask
  task automatic chk_mode(input logic [1:0] m);
    lfsrc_byte_t d;
    lfsrc_host_inst.read(`LFSRC_ADDR_CTL1, d);
    chk({6'h00, d[3:2]}, {6'h00, m});
  endtask
  task automatic set_mode(input logic [1:0] m);
    lfsrc_host_inst.write(`LFSRC_ADDR_CTL1, {1'b0, 3'h3, m, 2'h3});
  endtask

  task automatic t_reset;
    lfsrc_byte_t d;
    chk(rbyte, 8'hFF);
    chk_word(16'hFFFF);
    chk_mode(2'h0);
    lfsrc_host_inst.read(8'h00, d);
    chk(d, 8'h00);
  endtask
  task automatic t_seed_strobe;
    lfsrc_host_inst.seed(16'h1234);
    chk_word(16'h1234);
    lfsrc_host_inst.strobe(2);
    lfsrc_host_inst.idle(2);
    chk_word(adv(adv(16'h1234)));
  endtask
  task automatic t_modes;
    exp_w = 16'hACE1;
    lfsrc_host_inst.seed(exp_w);
    set_mode(2'h1);
    lfsrc_host_inst.idle(2);
    chk_mode(2'h0);
    exp_w = adv(exp_w);
    chk_word(exp_w);
    for (int m = 2; m < 4; m++) begin
      set_mode(m[1:0]);
      lfsrc_host_inst.strobe(3);
      lfsrc_host_inst.idle(2);
      chk_mode(m[1:0]);
      chk_word(exp_w);
    end
    set_mode(2'h0);
  endtask
  // Seed with all ones, then a burst of bytes on consecutive edges.
  task automatic t_crc;
    exp_w = 16'hFFFF;
    lfsrc_host_inst.seed(exp_w);
    for (int i = 0; i < 9; i++) begin
      lfsrc_host_inst.write(`LFSRC_ADDR_HIGH, 8'h31 + i[7:0]);
      exp_w = crc(exp_w, 8'h31 + i[7:0]);
    end
    lfsrc_host_inst.idle(2);
    chk_word(exp_w);
  endtask
  task automatic t_fixed;
    lfsrc_host_inst.seed(16'h8003);
    set_mode(2'h1);
    lfsrc_host_inst.idle(2);
    chk_word(16'h8003);
    lfsrc_host_inst.seed(16'h0000);
    lfsrc_host_inst.strobe(2);
    lfsrc_host_inst.idle(2);
    chk_word(16'h0000);
  endtask
  task automatic t_prio;
    lfsrc_host_inst.seed(16'h5A5A);
    lfsrc_host_inst.put(1'b1, 1'b0, 1'b1, `LFSRC_ADDR_LOW, 8'h3C);
    lfsrc_host_inst.idle(2);
    chk_word(16'h5A3C);
    lfsrc_host_inst.write(8'h00, 8'h77);
    lfsrc_host_inst.idle(1);
    chk_word(16'h5A3C);
    lfsrc_host_inst.put(1'b1, 1'b0, 1'b1, `LFSRC_ADDR_HIGH, 8'hC3);
    lfsrc_host_inst.idle(2);
    chk_word(crc(16'h5A3C, 8'hC3));
  endtask

  task automatic stop_test;
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    fail_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_seed_strobe;
    t_modes;
    t_crc;
    t_fixed;
    t_prio;
    stop_test;
  end
  // The scenarios need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    stop_test;
  end
endmodule

// ---- verilog/lfsrc_fifo.sv ----
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module lfsrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  lfsrc_stream_if.snk wr,
  lfsrc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = DEPTH[AW:0];

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        rdy;
  } lfsrc_fifo_st_t;

  lfsrc_fifo_st_t st_reg;
  lfsrc_fifo_st_t st_next;
  logic           push;
  logic           pop;

  // Ready is a flop so that the source sees a clean level.
  assign wr.ready = st_reg.rdy;
  assign rd.valid = (st_reg.cnt != '0);
  assign rd.data  = st_reg.mem[st_reg.rp];

  always_comb begin
    st_next = st_reg;
    push    = wr.valid && st_reg.rdy;
    pop     = rd.valid && rd.ready;
    if (push) begin
      st_next.mem[st_reg.wp] = wr.data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    st_next.rdy = (st_next.cnt != FULL);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg     <= '0;
      st_reg.rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ---- verilog/lfsrc_map.svh ----
// Register offsets, field positions, reset values and step counts.
`ifndef LFSRC_MAP_SVH
`define LFSRC_MAP_SVH
`define LFSRC_ADDR_CTL1      8'hB4
`define LFSRC_ADDR_LOW       8'hBC
`define LFSRC_ADDR_HIGH      8'hBD
`define LFSRC_MODE_MSB       3
`define LFSRC_MODE_LSB       2
`define LFSRC_MODE_NORMAL    2'h0
`define LFSRC_MODE_ONCE      2'h1
`define LFSRC_MODE_RSVD      2'h2
`define LFSRC_MODE_STOP      2'h3
`define LFSRC_RST_LFSR       16'hFFFF
`define LFSRC_RST_MODE       2'h0
`define LFSRC_RST_CTL_HI     3'h3
`define LFSRC_RST_CTL_LO     2'h3
`define LFSRC_RST_RDATA      8'h00
`define LFSRC_RST_RBYTE      8'hFF
`define LFSRC_POLY           16'h8005
`define LFSRC_FIX_A          16'h0000
`define LFSRC_FIX_B          16'h8003
`define LFSRC_RAND_SHIFTS    13
`define LFSRC_CRC_SHIFTS     8
`define LFSRC_FIFO_DEPTH     16
`define LFSRC_FIFO_WIDTH     8
`endif

// ---- verilog/lfsrc_pkg.sv ----
// Shared types of the random and CRC unit.
package lfsrc_pkg;
  typedef logic [7:0]  lfsrc_byte_t;
  typedef logic [15:0] lfsrc_word_t;
  typedef struct packed {
    lfsrc_word_t lfsr;
    logic [1:0]  mode;
    logic [2:0]  ctl_hi;
    logic [1:0]  ctl_lo;
    lfsrc_byte_t rdata;
    lfsrc_byte_t rbyte;
  } lfsrc_state_t;
endpackage

// ---- verilog/lfsrc_stream_if.sv ----
// Valid/ready byte stream between the unit's own modules.
`timescale 1ns/1ns
interface lfsrc_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- verilog/lfsrc_top.sv ----
// Random byte generator and CRC16 engine behind three byte registers.
`timescale 1ns/1ns
`include "lfsrc_map.svh"
module lfsrc_top (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   sfr_wr_i,
  input  wire logic                   sfr_rd_i,
  input  wire lfsrc_pkg::lfsrc_byte_t sfr_addr_i,
  input  wire lfsrc_pkg::lfsrc_byte_t sfr_wdata_i,
  output lfsrc_pkg::lfsrc_byte_t      sfr_rdata_o,
  input  wire logic                   csp_rand_rd_i,
  output lfsrc_pkg::lfsrc_byte_t      csp_rand_byte_o,
  output logic                        crc_in_ready_o
);
  import lfsrc_pkg::*;

  lfsrc_state_t st_reg;
  lfsrc_state_t st_next;
  lfsrc_word_t  rand_nxt;
  lfsrc_word_t  crc_nxt;
  logic         wr_low;
  logic         wr_high;
  logic         wr_ctl;
  logic         crc_go;
  logic         adv_req;
  logic         adv_go;

  lfsrc_stream_if #(.WIDTH(`LFSRC_FIFO_WIDTH)) crc_in ();
  lfsrc_stream_if #(.WIDTH(`LFSRC_FIFO_WIDTH)) crc_out ();

  assign wr_low  = sfr_wr_i && (sfr_addr_i == `LFSRC_ADDR_LOW);
  assign wr_high = sfr_wr_i && (sfr_addr_i == `LFSRC_ADDR_HIGH);
  assign wr_ctl  = sfr_wr_i && (sfr_addr_i == `LFSRC_ADDR_CTL1);

  // High-byte writes queue here; the CRC stage drains one per cycle.
  assign crc_in.valid = wr_high;
  assign crc_in.data  = sfr_wdata_i;
  assign crc_in_ready_o = crc_in.ready;

  // A seed write in the same cycle holds the queued byte back.
  assign crc_out.ready = !wr_low;
  assign crc_go = crc_out.valid && !wr_low;

  lfsrc_fifo #(
    .WIDTH (`LFSRC_FIFO_WIDTH),
    .DEPTH (`LFSRC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .wr      (crc_in),
    .rd      (crc_out)
  );

  lfsrc_unroll u_unroll (
    .state_i (st_reg.lfsr),
    .byte_i  (crc_out.data),
    .rand_o  (rand_nxt),
    .crc_o   (crc_nxt)
  );

  // Advance requests: strobe read in normal mode, or one-shot mode.
  always_comb begin
    adv_req = 1'b0;
    case (st_reg.mode)
      `LFSRC_MODE_NORMAL: adv_req = csp_rand_rd_i;
      `LFSRC_MODE_ONCE:   adv_req = 1'b1;
      `LFSRC_MODE_STOP:   adv_req = 1'b0;
      default:            adv_req = 1'b0;
    endcase
  end

  // Any data-path write wins; a dropped strobe advance is lost, while a
  // one-shot request simply waits, since its field stays at 01. A high
  // byte write also holds the advance off, so its CRC starts from the
  // state that software saw when it wrote.
  assign adv_go = adv_req && !wr_low && !wr_high && !crc_go;

  always_comb begin
    st_next = st_reg;
    if (wr_low) begin
      st_next.lfsr = {st_reg.lfsr[7:0], sfr_wdata_i};
    end else if (crc_go) begin
      st_next.lfsr = crc_nxt;
    end else if (adv_go) begin
      st_next.lfsr = rand_nxt;
    end
    if (adv_go && st_reg.mode == `LFSRC_MODE_ONCE) begin
      st_next.mode = `LFSRC_MODE_NORMAL;
    end
    // Software writes win over the hardware clear of the one-shot.
    if (wr_ctl) begin
      st_next.mode = sfr_wdata_i[`LFSRC_MODE_MSB:`LFSRC_MODE_LSB];
      st_next.ctl_hi = sfr_wdata_i[6:4];
      st_next.ctl_lo = sfr_wdata_i[1:0];
    end
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        `LFSRC_ADDR_LOW:  st_next.rdata = st_reg.lfsr[7:0];
        `LFSRC_ADDR_HIGH: st_next.rdata = st_reg.lfsr[15:8];
        `LFSRC_ADDR_CTL1: st_next.rdata = {1'b0, st_reg.ctl_hi,
                                           st_reg.mode, st_reg.ctl_lo};
        default:          st_next.rdata = 8'h00;
      endcase
    end
    st_next.rbyte = st_next.lfsr[7:0];
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_reg.lfsr   <= `LFSRC_RST_LFSR;
      st_reg.mode   <= `LFSRC_RST_MODE;
      st_reg.ctl_hi <= `LFSRC_RST_CTL_HI;
      st_reg.ctl_lo <= `LFSRC_RST_CTL_LO;
      st_reg.rdata  <= `LFSRC_RST_RDATA;
      st_reg.rbyte  <= `LFSRC_RST_RBYTE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sfr_rdata_o     = st_reg.rdata;
  assign csp_rand_byte_o = st_reg.rbyte;

  property p_reset_state;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !$past(rst_n_i) |-> st_reg.lfsr == `LFSRC_RST_LFSR &&
                        st_reg.mode == `LFSRC_RST_MODE;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("Shift register or mode wrong after reset.");

  property p_seed_shift;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_low |=> st_reg.lfsr == {$past(st_reg.lfsr[7:0]),
                               $past(sfr_wdata_i)};
  endproperty
  a_seed_shift: assert property (p_seed_shift)
    else $error("Low byte write did not shift the seed.");

  property p_seed_twice;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_low ##1 wr_low |=> st_reg.lfsr == {$past(sfr_wdata_i, 2),
                                          $past(sfr_wdata_i)};
  endproperty
  a_seed_twice: assert property (p_seed_twice)
    else $error("Two low writes did not form the full seed.");

  property p_read_low;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    sfr_rd_i && sfr_addr_i == `LFSRC_ADDR_LOW
      |=> sfr_rdata_o == $past(st_reg.lfsr[7:0]);
  endproperty
  a_read_low: assert property (p_read_low)
    else $error("Low read did not return the low shift byte.");

  property p_read_high;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    sfr_rd_i && sfr_addr_i == `LFSRC_ADDR_HIGH
      |=> sfr_rdata_o == $past(st_reg.lfsr[15:8]);
  endproperty
  a_read_high: assert property (p_read_high)
    else $error("High read did not return the high shift byte.");

  property p_strobe_adv;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_reg.mode == `LFSRC_MODE_NORMAL && csp_rand_rd_i && !wr_low &&
    !wr_high && !crc_out.valid |=> st_reg.lfsr == $past(rand_nxt);
  endproperty
  a_strobe_adv: assert property (p_strobe_adv)
    else $error("Strobe read did not advance the generator.");

  property p_once_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_reg.mode == `LFSRC_MODE_ONCE && !wr_low && !crc_out.valid &&
    !wr_ctl && !wr_high |=> st_reg.mode == `LFSRC_MODE_NORMAL &&
                st_reg.lfsr == $past(rand_nxt);
  endproperty
  a_once_clear: assert property (p_once_clear)
    else $error("One-shot advance did not run and clear.");

  property p_stopped;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_reg.mode == `LFSRC_MODE_STOP && !wr_low && !crc_out.valid
      |=> st_reg.lfsr == $past(st_reg.lfsr);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("Stopped generator changed state.");

  property p_fixed;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (st_reg.lfsr == `LFSRC_FIX_A || st_reg.lfsr == `LFSRC_FIX_B) &&
    !wr_low && !crc_out.valid |=> $stable(st_reg.lfsr);
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("A fixed-point seed moved on advancing.");

  property p_rand_byte;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    csp_rand_byte_o == st_reg.lfsr[7:0];
  endproperty
  a_rand_byte: assert property (p_rand_byte)
    else $error("Strobe byte differs from the low shift byte.");

  property p_crc_drain;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    crc_out.valid && !wr_low |=> st_reg.lfsr == $past(crc_nxt);
  endproperty
  a_crc_drain: assert property (p_crc_drain)
    else $error("Queued CRC byte was not processed.");

  property p_write_wins;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_low && adv_req |=> st_reg.lfsr[7:0] == $past(sfr_wdata_i);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("Advance overrode a register write.");

  property p_high_no_adv;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_high && !crc_out.valid |=> $stable(st_reg.lfsr);
  endproperty
  a_high_no_adv: assert property (p_high_no_adv)
    else $error("Advance ran in the cycle of a high byte write.");

  property p_rdata_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !sfr_rd_i |=> $stable(sfr_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data changed without a read.");

  property p_ctl_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    sfr_rd_i && sfr_addr_i == `LFSRC_ADDR_CTL1
      |=> sfr_rdata_o[`LFSRC_MODE_MSB:`LFSRC_MODE_LSB] == $past(st_reg.mode);
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("Control read did not show the mode field.");

  property p_ctl_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_ctl |=> st_reg.mode ==
      $past(sfr_wdata_i[`LFSRC_MODE_MSB:`LFSRC_MODE_LSB]);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("Control write did not store the mode field.");

  property p_reserved;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_reg.mode == `LFSRC_MODE_RSVD && !wr_low && !crc_out.valid
      |=> $stable(st_reg.lfsr);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved mode advanced the generator.");

  property p_crc_ready;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    crc_in_ready_o;
  endproperty
  a_crc_ready: assert property (p_crc_ready)
    else $error("CRC byte queue refused a high byte write.");

  property p_strobe_byte;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_reg.mode == `LFSRC_MODE_NORMAL && csp_rand_rd_i && !wr_low &&
    !wr_high && !crc_out.valid |=> csp_rand_byte_o == $past(rand_nxt[7:0]);
  endproperty
  a_strobe_byte: assert property (p_strobe_byte)
    else $error("Strobe byte was not the fresh low byte.");

  property p_once_wait;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_reg.mode == `LFSRC_MODE_ONCE && wr_low
      |=> st_reg.mode == `LFSRC_MODE_ONCE;
  endproperty
  a_once_wait: assert property (p_once_wait)
    else $error("One-shot request was lost under a seed write.");

  property p_unmapped_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    sfr_rd_i && sfr_addr_i != `LFSRC_ADDR_LOW &&
    sfr_addr_i != `LFSRC_ADDR_HIGH && sfr_addr_i != `LFSRC_ADDR_CTL1
      |=> sfr_rdata_o == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Unmapped read did not return zero.");

  c_seed_twice: cover property (@(posedge core_clk_i) disable iff
    (!rst_n_i) wr_low ##1 wr_low);
  c_crc_burst: cover property (@(posedge core_clk_i) disable iff
    (!rst_n_i) wr_high ##1 wr_high ##1 wr_high);
  c_strobe: cover property (@(posedge core_clk_i) disable iff
    (!rst_n_i) adv_go && st_reg.mode == `LFSRC_MODE_NORMAL);
  c_once: cover property (@(posedge core_clk_i) disable iff
    (!rst_n_i) adv_go && st_reg.mode == `LFSRC_MODE_ONCE);
  c_stop_strobe: cover property (@(posedge core_clk_i) disable iff
    (!rst_n_i) st_reg.mode == `LFSRC_MODE_STOP && csp_rand_rd_i);
endmodule

// ---- verilog/lfsrc_unroll.sv ----
// Unrolled next-state logic: thirteen free shifts and one CRC byte.
`timescale 1ns/1ns
`include "lfsrc_map.svh"
module lfsrc_unroll (
  input  wire lfsrc_pkg::lfsrc_word_t state_i,
  input  wire lfsrc_pkg::lfsrc_byte_t byte_i,
  output lfsrc_pkg::lfsrc_word_t      rand_o,
  output lfsrc_pkg::lfsrc_word_t      crc_o
);
  import lfsrc_pkg::*;

  // Galois form, so 0x0000 and 0x8003 map onto themselves.
  function automatic lfsrc_word_t step(input lfsrc_word_t s,
                                       input logic b);
    logic fb;
    fb   = s[15] ^ b;
    step = {s[14:0], 1'b0} ^ (fb ? `LFSRC_POLY : 16'h0000);
  endfunction

  always_comb begin
    lfsrc_word_t r;
    lfsrc_word_t c;
    r = state_i;
    c = state_i;
    for (int i = 0; i < `LFSRC_RAND_SHIFTS; i++) begin
      r = step(r, 1'b0);
    end
    for (int i = `LFSRC_CRC_SHIFTS - 1; i >= 0; i--) begin
      c = step(c, byte_i[i]);
    end
    rand_o = r;
    crc_o  = c;
  end
endmodule
